// ===== core/scsd_module_side.v
// module-side socket strap, wake, power-cut, alert, audio and antenna pin logic
// Operation
// - module grounds or leaves open each strap per type, interface, port config.
// - module wakes host with one 1 second low pulse on open-drain line.
// - audio pins follow I2S or SLIMbus pin roles per selected mode.
// - general-purpose antenna mode drives a 4-bit value, line 0 lsb.
// - front-end serial mode: line1 data, line2 clock, line3 supply ref.
// - power-cut input is asynchronous; radio power drops while asserted.
// - storage module asks for attention by pulling the alert line low.
// - reserved pins get no function and stay undriven.
// - port config selects the function of the wake pin and the four audio pins.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "scsd_defs.vh"

module scsd_module_side #(
	parameter integer WAKE_CYCLES = `SCSD_WAKE_CYCLES
) (
	input wire mclk,
	input wire sys_rst,
	input wire ce,
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdData,
	output reg [3:0] strapOut,
	output reg [3:0] strapOe_n,
	output reg hostWakeOut,
	output reg hostWakeOe_n,
	input wire txPowerCutReq,
	output reg txPowerReduce,
	output reg alertOut,
	output reg alertOe_n,
	input wire [3:0] audioIn,
	output reg [3:0] audioOut,
	output reg [3:0] audioOe_n,
	input wire audClkOut,
	input wire audClkDrive,
	input wire audTxData,
	input wire audWsOut,
	input wire audWsDrive,
	input wire slimDataOut,
	input wire slimDataDrive,
	output reg audClkIn,
	output reg audRxData,
	output reg audWsIn,
	output reg slimDataIn,
	input wire [3:0] antennaIn,
	output reg [3:0] antennaOut,
	output reg [3:0] antennaOe_n,
	input wire rffeDataOut,
	input wire rffeDataDrive,
	input wire rffeClk,
	input wire rffeSupplyRef,
	output reg rffeDataIn
);

	reg [5:0] cfg;
	reg alertReq;
	reg [1:0] audMode;
	reg antMode;
	reg [3:0] antValue;
	reg [31:0] wakeCount;
	reg wakeBusy;
	reg txCutMeta;
	reg txCutSync;
	reg [3:0] next_state;
	reg [3:0] next_strap;
	reg [3:0] next_audOut;
	reg [3:0] next_audOe_n;
	reg [3:0] next_antOut;
	reg [3:0] next_antOe_n;
	wire isRadio;
	wire [1:0] hostIf;
	wire [1:0] portCfg;
	wire wakeAllowed;
	wire audioAllowed;
	wire cfgWrite;
	wire ctrlWrite;
	wire wakeStart;

	// encodes the module's identity into the 4-bit strap state number
	function [3:0] encode_state;
		input [5:0] c;
		begin
			if (!c[`SCSD_CFG_PRESENT]) begin
				encode_state = `SCSD_STATE_NONE;
			end else if (!c[`SCSD_CFG_RADIO]) begin
				// storage carries no port config; sata or pcie only
				encode_state = {3'h0, c[`SCSD_CFG_HOST_LO]};
			end else begin
				case (c[`SCSD_CFG_HOST_HI:`SCSD_CFG_HOST_LO])
					`SCSD_HOST_PCIE: begin
						// port configs 2 and 3 jump to states 12 and 13
						encode_state = c[`SCSD_CFG_PORT_HI] ?
							{3'h6, c[`SCSD_CFG_PORT_LO]} :
							{3'h1, c[`SCSD_CFG_PORT_LO]};
					end
					`SCSD_HOST_USB3: begin
						encode_state = `SCSD_STATE_USB3_BASE |
							{2'h0, c[`SCSD_CFG_PORT_HI:`SCSD_CFG_PORT_LO]};
					end
					`SCSD_HOST_SSIC: begin
						encode_state = `SCSD_STATE_SSIC_BASE |
							{2'h0, c[`SCSD_CFG_PORT_HI:`SCSD_CFG_PORT_LO]};
					end
					default: begin
						// undefined interface code: present nothing rather than state 14
						encode_state = `SCSD_STATE_NONE;
					end
				endcase
			end
		end
	endfunction

	// true for a strobe aimed at one register offset
	function reg_hit;
		input strobe;
		input [7:0] addr;
		input [7:0] target;
		begin
			reg_hit = strobe && (addr == target);
		end
	endfunction

	// straps leave the socket as strap0 msb, strap3, strap2, strap1 lsb
	function [3:0] strap_pins;
		input [3:0] s;
		begin
			// result bit n drives strap n
			strap_pins = {s[2], s[1], s[0], s[3]};
		end
	endfunction

	assign isRadio = cfg[`SCSD_CFG_RADIO] & cfg[`SCSD_CFG_PRESENT];
	assign hostIf = cfg[`SCSD_CFG_HOST_HI:`SCSD_CFG_HOST_LO];
	assign portCfg = cfg[`SCSD_CFG_PORT_HI:`SCSD_CFG_PORT_LO];
	// the wake pin becomes strobe/data in port config 3
	assign wakeAllowed = isRadio & (portCfg != `SCSD_PORT_HSIC);
	// audio pins are reserved in port config 2
	assign audioAllowed = isRadio & (portCfg != `SCSD_PORT_UIM2);

	// decoded register strobes
	assign cfgWrite = reg_hit(regWr, regAddr, `SCSD_ADDR_CFG);
	assign ctrlWrite = reg_hit(regWr, regAddr, `SCSD_ADDR_CTRL);
	assign wakeStart = ctrlWrite & regWrData[`SCSD_CTRL_WAKE] & wakeAllowed;

	always @* begin
		next_state = encode_state(cfg);
		next_strap = strap_pins(next_state);
	end

	always @* begin
		next_audOut = 4'h0;
		next_audOe_n = 4'hF;
		if (audioAllowed && audMode == `SCSD_AUD_I2S) begin
			next_audOut = {audWsOut, audTxData, 1'b0, audClkOut};
			next_audOe_n = {~audWsDrive, 1'b0, 1'b1, ~audClkDrive};
		end else if (audioAllowed && audMode == `SCSD_AUD_SLIM) begin
			next_audOut = {2'h0, slimDataOut, audClkOut};
			next_audOe_n = {2'h3, ~slimDataDrive, 1'b0};
		end
	end

	always @* begin
		if (!isRadio) begin
			next_antOut = 4'h0;
			next_antOe_n = 4'hF;
		end else if (!antMode) begin
			next_antOut = antValue;
			next_antOe_n = 4'h0;
		end else begin
			next_antOut = {rffeSupplyRef, rffeClk, rffeDataOut, 1'b0};
			next_antOe_n = {1'b0, 1'b0, ~rffeDataDrive, 1'b1};
		end
	end

	// register file and control
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg <= `SCSD_CFG_RESET;
			alertReq <= 1'b0;
			audMode <= `SCSD_AUD_OFF;
			antMode <= 1'b0;
			antValue <= 4'h0;
			regRdData <= 32'h0;
		end else if (ce) begin
			if (cfgWrite) begin
				cfg <= regWrData[5:0];
			end
			if (ctrlWrite) begin
				alertReq <= regWrData[`SCSD_CTRL_ALERT];
				audMode <= regWrData[`SCSD_CTRL_AUD_HI:`SCSD_CTRL_AUD_LO];
				antMode <= regWrData[`SCSD_CTRL_ANT_MODE];
				antValue <= regWrData[`SCSD_CTRL_ANT_HI:`SCSD_CTRL_ANT_LO];
			end
			regRdData <= 32'h0;
			if (regRd) begin
				case (regAddr)
					`SCSD_ADDR_CFG: begin
						regRdData <= {26'h0, cfg};
					end
					`SCSD_ADDR_CTRL: begin
						regRdData <= {20'h0, antValue, 3'h0, antMode, audMode, alertReq, 1'b0};
					end
					`SCSD_ADDR_STATUS: begin
						regRdData <= {24'h0, alertReq & ~alertOe_n, wakeAllowed, next_state,
							txCutSync, wakeBusy};
					end
					default: begin
						regRdData <= 32'h0;
					end
				endcase
			end
		end
	end

	// wake pulse: a start request while busy or not allowed is dropped
	// ce low stretches the pulse, since the counter freezes with everything else
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wakeBusy <= 1'b0;
			wakeCount <= 32'h0;
			hostWakeOut <= 1'b0;
			hostWakeOe_n <= 1'b1;
		end else if (ce) begin
			if (wakeBusy) begin
				if (wakeCount == WAKE_CYCLES - 1) begin
					wakeBusy <= 1'b0;
					hostWakeOe_n <= 1'b1;
				end
				wakeCount <= wakeCount + 32'h1;
			end else if (wakeStart) begin
				wakeBusy <= 1'b1;
				wakeCount <= 32'h0;
				hostWakeOe_n <= 1'b0;
			end
			hostWakeOut <= 1'b0;
		end
	end

	// power-cut input crosses in through two flops before it is used
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			txCutMeta <= 1'b0;
			txCutSync <= 1'b0;
			txPowerReduce <= 1'b0;
		end else if (ce) begin
			txCutMeta <= txPowerCutReq;
			txCutSync <= txCutMeta;
			txPowerReduce <= txCutSync & isRadio;
		end
	end

	// pin drivers, all registered
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			strapOut <= 4'h0;
			strapOe_n <= 4'hF;
			alertOut <= 1'b0;
			alertOe_n <= 1'b1;
			audioOut <= 4'h0;
			audioOe_n <= 4'hF;
			antennaOut <= 4'h0;
			antennaOe_n <= 4'hF;
			audClkIn <= 1'b0;
			audRxData <= 1'b0;
			audWsIn <= 1'b0;
			slimDataIn <= 1'b0;
			rffeDataIn <= 1'b0;
		end else if (ce) begin
			// a one strap bit is left open, a zero is grounded
			strapOut <= 4'h0;
			strapOe_n <= next_strap;
			alertOut <= 1'b0;
			// attention only meaningful for a present storage module
			alertOe_n <= ~(alertReq & cfg[`SCSD_CFG_PRESENT] & ~cfg[`SCSD_CFG_RADIO]);
			audioOut <= next_audOut;
			audioOe_n <= next_audOe_n;
			antennaOut <= next_antOut;
			antennaOe_n <= next_antOe_n;
			// inputs are copied even while a pin is reserved; users must ignore them then
			audClkIn <= audioIn[0];
			audRxData <= audioIn[1];
			audWsIn <= audioIn[3];
			slimDataIn <= audioIn[1];
			rffeDataIn <= antennaIn[1];
		end
	end

endmodule

// ===== core/scsd_defs.vh
// constants for the socket configuration and sideband block
`ifndef SCSD_DEFS_VH
`define SCSD_DEFS_VH

`define SCSD_ADDR_CFG 8'h00
`define SCSD_ADDR_CTRL 8'h04
`define SCSD_ADDR_STATUS 8'h08

`define SCSD_CFG_RADIO 0
`define SCSD_CFG_HOST_LO 1
`define SCSD_CFG_HOST_HI 2
`define SCSD_CFG_PORT_LO 3
`define SCSD_CFG_PORT_HI 4
`define SCSD_CFG_PRESENT 5
`define SCSD_CFG_RESET 6'h00

`define SCSD_CTRL_WAKE 0
`define SCSD_CTRL_ALERT 1
`define SCSD_CTRL_AUD_LO 2
`define SCSD_CTRL_AUD_HI 3
`define SCSD_CTRL_ANT_MODE 4
`define SCSD_CTRL_ANT_LO 8
`define SCSD_CTRL_ANT_HI 11

`define SCSD_HOST_PCIE 2'h0
`define SCSD_HOST_USB3 2'h1
`define SCSD_HOST_SSIC 2'h2
`define SCSD_HOST_SATA 2'h0

`define SCSD_AUD_OFF 2'h0
`define SCSD_AUD_I2S 2'h1
`define SCSD_AUD_SLIM 2'h2

`define SCSD_STATE_NONE 4'hF
`define SCSD_STATE_USB3_BASE 4'h4
`define SCSD_STATE_SSIC_BASE 4'h8
`define SCSD_PORT_HSIC 2'h3
`define SCSD_PORT_UIM2 2'h2

`define SCSD_WAKE_PULSE_MS 1000
`define SCSD_CLK_KHZ 20000
`define SCSD_WAKE_CYCLES (`SCSD_WAKE_PULSE_MS * `SCSD_CLK_KHZ)

`endif

// ===== tb/scsd_module_side_props.sv
// assertions on the module-side socket block ports
`timescale 1ns/1ps
module scsd_module_side_props #(
	parameter integer WAKE_CYCLES = 16
) (
	input wire mclk,
	input wire sys_rst,
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire [3:0] strapOut,
	input wire [3:0] strapOe_n,
	input wire hostWakeOut,
	input wire hostWakeOe_n,
	input wire txPowerCutReq,
	input wire txPowerReduce,
	input wire alertOe_n,
	input wire audClkOut,
	input wire [3:0] audioOut,
	input wire [3:0] audioOe_n
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	wire cfgWr = regWr && regAddr == 8'h00;
	wire ctrlWr = regWr && regAddr == 8'h04;
	reg [31:0] lowCnt;
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			lowCnt <= 32'h0;
		else
			lowCnt <= hostWakeOe_n ? 32'h0 : lowCnt + 32'h1;
	end
	strap_drive_a: assert property (strapOut == 4'h0)
		else $error("strap driven high");
	strap_change_a: assert property ($changed(strapOe_n) |-> $past(cfgWr, 2))
		else $error("straps moved without config write");
	wake_drive_a: assert property (hostWakeOut == 1'b0)
		else $error("wake line driven high");
	wake_start_a: assert property ($fell(hostWakeOe_n) |-> $past(ctrlWr && regWrData[0]))
		else $error("wake pulse without start");
	wake_len_a: assert property ($rose(hostWakeOe_n) |-> lowCnt == WAKE_CYCLES)
		else $error("wake pulse length wrong");
	pwr_cut_a: assert property (txPowerReduce |-> $past(txPowerCutReq, 3))
		else $error("power reduce without request");
	alert_start_a: assert property ($fell(alertOe_n) |-> $past(ctrlWr && regWrData[1], 2))
		else $error("alert without request");
	aud_clk_a: assert property (!audioOe_n[0] |-> audioOut[0] == $past(audClkOut))
		else $error("audio clock pin wrong");
endmodule
bind scsd_module_side scsd_module_side_props #(.WAKE_CYCLES(WAKE_CYCLES)) props (
	.mclk, .sys_rst, .regAddr, .regWrData, .regWr, .strapOut, .strapOe_n,
	.hostWakeOut, .hostWakeOe_n, .txPowerCutReq, .txPowerReduce, .alertOe_n,
	.audClkOut, .audioOut, .audioOe_n
);

// ===== tb/scsd_platform_model.sv
// platform-side model: strap pull-ups, filtered decode, wake pulse timing
`timescale 1ns/1ps
module scsd_platform_model (
	input wire mclk,
	input wire [3:0] strapOut,
	input wire [3:0] strapOe_n,
	input wire hostWakeOut,
	input wire hostWakeOe_n,
	output logic [3:0] strapState = 4'hF,
	output logic [31:0] wakeLen = 32'h0,
	output logic [3:0] portInfo
);
	// the block has no management bus or factory test pins, so this side
	// neither clocks a bus nor touches those pins
	wire [3:0] pin = strapOe_n | strapOut;
	wire wakeLine = hostWakeOe_n | hostWakeOut;
	logic [3:0] s1 = 4'hF;
	logic [3:0] s2 = 4'hF;
	logic [3:0] s3 = 4'hF;
	logic [31:0] lowCnt = 32'h0;
	// port config exists for radio states only; config 3 alone offers strobe/data
	always_comb begin
		case (strapState)
			4'h2, 4'h3: portInfo = {3'h2, strapState[0]};
			4'hC, 4'hD: portInfo = {3'h3, strapState[0]};
			4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB: portInfo = {2'h1, strapState[1:0]};
			default: portInfo = 4'h0;
		endcase
		portInfo[3] = portInfo[2] & (portInfo[1:0] == 2'h3);
	end
	always @(posedge mclk) begin
		s1 <= pin;
		s2 <= s1;
		s3 <= s2;
		// a strap still settling must not flash a wrong module type
		if (s3 == s2)
			strapState <= {s2[0], s2[3], s2[2], s2[1]};
		lowCnt <= wakeLine ? 32'h0 : lowCnt + 32'h1;
		if (wakeLine && lowCnt != 32'h0)
			wakeLen <= lowCnt;
	end
endmodule

// ===== tb/tb_top.sv
// testbench for the module-side socket block
`timescale 1ns/1ps
module tb_top;
	localparam integer WK = 16;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic txPowerCutReq = 1'b0;
	logic [3:0] audioIn = 4'h0;
	logic [3:0] antennaIn = 4'h0;
	logic slimDataOut = 1'b0;
	logic slimDataDrive = 1'b0;
	logic [7:0] u = 8'h00;
	wire audClkOut = u[0];
	wire audClkDrive = u[1];
	wire rffeDataDrive = u[1];
	wire audTxData = u[2];
	wire audWsOut = u[3];
	wire audWsDrive = u[4];
	wire rffeClk = u[5];
	wire rffeSupplyRef = u[6];
	wire rffeDataOut = u[7];
	logic [31:0] regRdData;
	logic [3:0] strapOut, strapOe_n, audioOut, audioOe_n, antennaOut, antennaOe_n;
	logic hostWakeOut, hostWakeOe_n, txPowerReduce, alertOut, alertOe_n;
	logic audClkIn, audRxData, audWsIn, slimDataIn, rffeDataIn;
	logic [3:0] strapState;
	logic [31:0] wakeLen;
	logic [3:0] portInfo;
	logic [3:0] piTab [10] = '{4'h0, 4'h0, 4'h4, 4'h5, 4'h6, 4'hF, 4'hF, 4'h4, 4'hF, 4'h0};
	int fail_count = 0;
	int check_count = 0;
	logic [5:0] cfgTab [10] = '{6'h20, 6'h22, 6'h21, 6'h29, 6'h31, 6'h39, 6'h3B, 6'h25, 6'h3D, 6'h00};
	logic [3:0] stTab [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hC, 4'hD, 4'h7, 4'h8, 4'hB, 4'hF};
	always #25 mclk = ~mclk;
	scsd_module_side #(.WAKE_CYCLES(WK)) dut (.*);
	scsd_platform_model plat (.*);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 chk(regRdData, e);
	endtask
	task strap_scan;
		for (int i = 0; i < 10; i++) begin
			wr(8'h00, 32'(cfgTab[i]));
			repeat (8) @(posedge mclk);
			chk(32'(strapState), 32'(stTab[i]));
			chk(32'(portInfo), 32'(piTab[i]));
		end
	endtask
	task wake_pulse;
		wr(8'h00, 32'h21);
		wr(8'h04, 32'h1);
		repeat (WK + 4) @(posedge mclk);
		chk(wakeLen, WK);
		// port config 3 gives the wake pin to the strobe/data link: start is dropped
		wr(8'h00, 32'h39);
		wr(8'h04, 32'h1);
		repeat (2) @(posedge mclk);
		#1 chk(32'(hostWakeOe_n), 32'h1);
		rd(8'h08, 32'h34);
	endtask
	task power_cut;
		@(posedge mclk);
		txPowerCutReq <= 1'b1; // debounced level
		repeat (4) @(posedge mclk);
		#1 chk(32'(txPowerReduce), 32'h1);
		rd(8'h08, 32'h36);
		@(posedge mclk);
		txPowerCutReq <= 1'b0;
		repeat (4) @(posedge mclk);
		#1 chk(32'(txPowerReduce), 32'h0);
	endtask
	task pin_modes;
		@(posedge mclk);
		u <= 8'h1B;
		wr(8'h04, 32'hA04);
		repeat (2) @(posedge mclk);
		#1 chk({audioOe_n, audioOut, antennaOe_n, antennaOut}, 32'h290A);
		@(posedge mclk);
		u <= 8'hDF;
		slimDataOut <= 1'b1;
		slimDataDrive <= 1'b1;
		audioIn <= 4'h9;
		antennaIn <= 4'h2;
		wr(8'h04, 32'h18);
		repeat (2) @(posedge mclk);
		#1 chk({audioOe_n, audioOut, antennaOe_n, antennaOut}, 32'hC31A);
		chk({audClkIn, audRxData, audWsIn, slimDataIn, rffeDataIn}, 32'h15);
		@(posedge mclk);
		audioIn <= 4'h6;
		antennaIn <= 4'hD;
		repeat (2) @(posedge mclk);
		#1 chk({audClkIn, audRxData, audWsIn, slimDataIn, rffeDataIn}, 32'h0A);
		// port config 2 reserves the audio pins: all undriven
		wr(8'h00, 32'h31);
		repeat (2) @(posedge mclk);
		#1 chk({audioOe_n, audioOut}, 32'hF0);
	endtask
	task alert_req;
		wr(8'h00, 32'h20);
		wr(8'h04, 32'h2);
		repeat (2) @(posedge mclk);
		#1 chk(32'(alertOe_n), 32'h0);
		chk({alertOut, hostWakeOut, strapOut}, 32'h0);
		rd(8'h00, 32'h20);
		rd(8'h04, 32'h2);
		rd(8'h08, 32'h80);
		rd(8'h14, 32'h0);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(8'h00, 32'h0);
		strap_scan;
		wake_pulse;
		power_cut;
		pin_modes;
		alert_req;
		final_report;
	end
endmodule
